// [rtl/stepper_current_step_alarm_regs.sv]
// Current-control timing, ADC, overcurrent, step mode and alarm mask registers,
// with the electrical position counter, the busy/sync pin and the alarm pin.
// Assumes the command layer presents one register access per cmd_valid pulse.
`timescale 1ns/100ps

module stepper_current_step_alarm_regs #(
    parameter int POS_W = stepper_regs_pkg::ELECTRICAL_POSITION_W
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic cmd_valid,
    input stepper_regs_pkg::reg_cmd_s cmd,
    input wire logic motor_running,
    input wire logic cmd_busy,
    input wire logic status_fetch,
    input wire logic adc_valid,
    input wire logic [4:0] adc_code,
    input wire logic step_pulse,
    input wire logic step_dir,
    input stepper_regs_pkg::alarm_cond_s alarm_cond,
    output logic rd_valid_q,
    output logic [7:0] rd_data_q,
    output logic cmd_not_performed_q,
    output logic [POS_W-1:0] electrical_position_q,
    output logic [3:0] max_fast_decay_time_q,
    output logic [3:0] fall_step_time_q,
    output logic [6:0] min_on_time_q,
    output logic [6:0] min_off_time_q,
    output logic [3:0] overcurrent_threshold_q,
    output logic [2:0] step_res_q,
    output logic [10:0] fast_decay_cycles_q,
    output logic [10:0] fall_step_cycles_q,
    output logic [11:0] min_on_cycles_q,
    output logic [11:0] min_off_cycles_q,
    output logic [12:0] ocd_trip_ma_q,
    output logic [12:0] adc_current_ma_q,
    output logic busy_sync_q,
    output logic alarm_pin_out_q,
    output logic alarm_pin_oe_q
);

    logic [7:0] fast_decay_q;
    logic [4:0] adc_q;
    logic [7:0] step_cfg_q;
    logic [7:0] alarm_mask_q;

    logic wr;
    logic rd;
    logic locked_reg;
    logic refuse;
    logic wr_ok;
    logic [2:0] new_res;
    logic [POS_W-1:0] pos_inc;
    logic [7:0] rd_mux;
    logic [7:0] alarm_vec;
    logic sync_bit;

    assign wr = cmd_valid && cmd.write;
    assign rd = cmd_valid && !cmd.write;
    assign new_res = cmd.wdata[stepper_regs_pkg::SC_RES_HI:stepper_regs_pkg::SC_RES_LO];

    // Registers frozen while the motor runs
    always_comb begin
        locked_reg = 1'b0;
        if (cmd.addr == stepper_regs_pkg::ADDR_FAST_DECAY) begin
            locked_reg = 1'b1;
        end else if (cmd.addr == stepper_regs_pkg::ADDR_MIN_ON) begin
            locked_reg = 1'b1;
        end else if (cmd.addr == stepper_regs_pkg::ADDR_MIN_OFF) begin
            locked_reg = 1'b1;
        end else if (cmd.addr == stepper_regs_pkg::ADDR_STEP_CFG) begin
            locked_reg = 1'b1;
        end
    end

    assign refuse = wr && ((locked_reg && motor_running) ||
                           (cmd.addr == stepper_regs_pkg::ADDR_ADC));
    assign wr_ok = wr && !refuse;

    // One block per register; a refused write never reaches them
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_decay_q <= stepper_regs_pkg::RST_FAST_DECAY;
        end else if (clk_en && wr_ok && cmd.addr == stepper_regs_pkg::ADDR_FAST_DECAY) begin
            fast_decay_q <= cmd.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            min_on_time_q <= stepper_regs_pkg::RST_MIN_ON;
        end else if (clk_en && wr_ok && cmd.addr == stepper_regs_pkg::ADDR_MIN_ON) begin
            min_on_time_q <= cmd.wdata[6:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            min_off_time_q <= stepper_regs_pkg::RST_MIN_OFF;
        end else if (clk_en && wr_ok && cmd.addr == stepper_regs_pkg::ADDR_MIN_OFF) begin
            min_off_time_q <= cmd.wdata[6:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            overcurrent_threshold_q <= stepper_regs_pkg::RST_OVERCURRENT_THRESHOLD;
        end else if (clk_en && wr_ok && cmd.addr == stepper_regs_pkg::ADDR_OVERCURRENT_THRESHOLD) begin
            overcurrent_threshold_q <= cmd.wdata[3:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            alarm_mask_q <= stepper_regs_pkg::RST_ALARM_MASK;
        end else if (clk_en && wr_ok && cmd.addr == stepper_regs_pkg::ADDR_ALARM_MASK) begin
            alarm_mask_q <= cmd.wdata;
        end
    end

    // Bit 3 is stored as written; the host is expected to keep it one
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            step_cfg_q <= stepper_regs_pkg::RST_STEP_CFG;
        end else if (clk_en && wr_ok && cmd.addr == stepper_regs_pkg::ADDR_STEP_CFG) begin
            step_cfg_q <= cmd.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            adc_q <= 5'h00;
        end else if (clk_en && adc_valid) begin
            adc_q <= adc_code;
        end
    end

    // Set beats a status fetch in the same cycle so no refusal is lost
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_not_performed_q <= 1'b0;
        end else if (clk_en) begin
            if (refuse) begin
                cmd_not_performed_q <= 1'b1;
            end else if (status_fetch) begin
                cmd_not_performed_q <= 1'b0;
            end
        end
    end

    assign max_fast_decay_time_q = fast_decay_q[stepper_regs_pkg::FD_MAX_HI:
                                                stepper_regs_pkg::FD_MAX_LO];
    assign fall_step_time_q = fast_decay_q[stepper_regs_pkg::FD_FALL_HI:
                                           stepper_regs_pkg::FD_FALL_LO];
    assign step_res_q = step_cfg_q[stepper_regs_pkg::SC_RES_HI:stepper_regs_pkg::SC_RES_LO];

    // Derived times and currents, one cycle behind the stored codes
    // Eleven bits because the longest fast decay is 1600 cycles
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_decay_cycles_q <= 11'h000;
        end else if (clk_en) begin
            fast_decay_cycles_q <= 11'((32'(max_fast_decay_time_q) + 1) *
                                       stepper_regs_pkg::FAST_UNIT_CYC);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fall_step_cycles_q <= 11'h000;
        end else if (clk_en) begin
            fall_step_cycles_q <= 11'((32'(fall_step_time_q) + 1) *
                                      stepper_regs_pkg::FAST_UNIT_CYC);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            min_on_cycles_q <= 12'h000;
        end else if (clk_en) begin
            min_on_cycles_q <= 12'((32'(min_on_time_q) + 1) *
                                   stepper_regs_pkg::HALF_US_CYC);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            min_off_cycles_q <= 12'h000;
        end else if (clk_en) begin
            min_off_cycles_q <= 12'((32'(min_off_time_q) + 1) *
                                    stepper_regs_pkg::HALF_US_CYC);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ocd_trip_ma_q <= 13'h0000;
        end else if (clk_en) begin
            ocd_trip_ma_q <= 13'((32'(overcurrent_threshold_q) + 1) *
                                 stepper_regs_pkg::OCD_STEP_MA);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            adc_current_ma_q <= 13'h0000;
        end else if (clk_en) begin
            adc_current_ma_q <= 13'((32'(adc_q) + 1) *
                                    stepper_regs_pkg::ADC_STEP_MA);
        end
    end

    // Microstep increment per step pulse in 1/128 step units
    always_comb begin
        pos_inc = '0;
        case (step_res_q)
            3'h0: pos_inc = POS_W'(128);
            3'h1: pos_inc = POS_W'(64);
            3'h2: pos_inc = POS_W'(32);
            3'h3: pos_inc = POS_W'(16);
            default: pos_inc = POS_W'(8);
        endcase
    end

    // Wraps through four full steps; top two bits are the full step
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            electrical_position_q <= '0;
        end else if (clk_en) begin
            if (wr_ok && cmd.addr == stepper_regs_pkg::ADDR_STEP_CFG &&
                new_res != step_res_q) begin
                electrical_position_q <= '0;
            end else if (step_pulse) begin
                if (step_dir) begin
                    electrical_position_q <= electrical_position_q + pos_inc;
                end else begin
                    electrical_position_q <= electrical_position_q - pos_inc;
                end
            end
        end
    end

    // Source code selects position bit 7 down to 3
    always_comb begin
        sync_bit = 1'b0;
        case (step_cfg_q[stepper_regs_pkg::SC_SRC_HI:stepper_regs_pkg::SC_SRC_LO])
            3'h0: sync_bit = electrical_position_q[7];
            3'h1: sync_bit = electrical_position_q[6];
            3'h2: sync_bit = electrical_position_q[5];
            3'h3: sync_bit = electrical_position_q[4];
            3'h4: sync_bit = electrical_position_q[3];
            default: sync_bit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_sync_q <= 1'b1;
        end else if (clk_en) begin
            if (step_cfg_q[stepper_regs_pkg::SC_SYNC_EN]) begin
                busy_sync_q <= sync_bit;
            end else begin
                busy_sync_q <= !cmd_busy;
            end
        end
    end

    // Command error covers a refused and an unknown command
    always_comb begin
        alarm_vec = 8'h00;
        alarm_vec[stepper_regs_pkg::AM_OCD] = alarm_cond.ocd;
        alarm_vec[stepper_regs_pkg::AM_TH_SD] = alarm_cond.th_sd;
        alarm_vec[stepper_regs_pkg::AM_TH_WRN] = alarm_cond.th_wrn;
        alarm_vec[stepper_regs_pkg::AM_UVLO] = alarm_cond.uvlo;
        alarm_vec[stepper_regs_pkg::AM_SW_EVN] = alarm_cond.sw_evn;
        alarm_vec[stepper_regs_pkg::AM_CMD_ERR] = alarm_cond.wrong_cmd ||
                                                  cmd_not_performed_q;
    end

    // Open drain: only ever drives low
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            alarm_pin_out_q <= 1'b0;
            alarm_pin_oe_q <= 1'b0;
        end else if (clk_en) begin
            alarm_pin_out_q <= 1'b0;
            alarm_pin_oe_q <= |(alarm_vec & alarm_mask_q);
        end
    end

    // Unmapped addresses read as zero
    always_comb begin
        rd_mux = 8'h00;
        if (cmd.addr == stepper_regs_pkg::ADDR_FAST_DECAY) begin
            rd_mux = fast_decay_q;
        end else if (cmd.addr == stepper_regs_pkg::ADDR_MIN_ON) begin
            rd_mux = {1'b0, min_on_time_q};
        end else if (cmd.addr == stepper_regs_pkg::ADDR_MIN_OFF) begin
            rd_mux = {1'b0, min_off_time_q};
        end else if (cmd.addr == stepper_regs_pkg::ADDR_ADC) begin
            rd_mux = {3'h0, adc_q};
        end else if (cmd.addr == stepper_regs_pkg::ADDR_OVERCURRENT_THRESHOLD) begin
            rd_mux = {4'h0, overcurrent_threshold_q};
        end else if (cmd.addr == stepper_regs_pkg::ADDR_STEP_CFG) begin
            rd_mux = step_cfg_q;
        end else if (cmd.addr == stepper_regs_pkg::ADDR_ALARM_MASK) begin
            rd_mux = alarm_mask_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= 8'h00;
        end else if (clk_en) begin
            rd_valid_q <= rd;
            if (rd) begin
                rd_data_q <= rd_mux;
            end
        end
    end

endmodule

// [rtl/stepper_regs_pkg.sv]
// Shared constants and carriers of the stepper current, step and alarm registers.
// Assumes a command layer that has already decoded the serial frames from the host.
package stepper_regs_pkg;

    // Register indices on the parameter address bus
    localparam logic [4:0] ADDR_FAST_DECAY = 5'h0E;
    localparam logic [4:0] ADDR_MIN_ON = 5'h0F;
    localparam logic [4:0] ADDR_MIN_OFF = 5'h10;
    localparam logic [4:0] ADDR_ADC = 5'h12;
    localparam logic [4:0] ADDR_OVERCURRENT_THRESHOLD = 5'h13;
    localparam logic [4:0] ADDR_STEP_CFG = 5'h16;
    localparam logic [4:0] ADDR_ALARM_MASK = 5'h17;

    // Values after reset
    localparam logic [7:0] RST_FAST_DECAY = 8'h00;
    localparam logic [6:0] RST_MIN_ON = 7'h00;
    localparam logic [6:0] RST_MIN_OFF = 7'h00;
    localparam logic [3:0] RST_OVERCURRENT_THRESHOLD = 4'h0;
    localparam logic [7:0] RST_STEP_CFG = 8'h08;
    localparam logic [7:0] RST_ALARM_MASK = 8'hFF;

    // Field positions
    localparam int FD_MAX_HI = 7;
    localparam int FD_MAX_LO = 4;
    localparam int FD_FALL_HI = 3;
    localparam int FD_FALL_LO = 0;
    localparam int SC_SYNC_EN = 7;
    localparam int SC_SRC_HI = 6;
    localparam int SC_SRC_LO = 4;
    localparam int SC_RES_HI = 2;
    localparam int SC_RES_LO = 0;
    localparam int AM_OCD = 0;
    localparam int AM_TH_SD = 1;
    localparam int AM_TH_WRN = 2;
    localparam int AM_UVLO = 3;
    localparam int AM_SW_EVN = 6;
    localparam int AM_CMD_ERR = 7;

    // Time units and cycle counts at the system clock
    localparam int CLK_MHZ = 50;
    localparam int FAST_UNIT_NS = 2000;
    localparam int HALF_US_NS = 500;
    localparam int FAST_UNIT_CYC = FAST_UNIT_NS * CLK_MHZ / 1000;
    localparam int HALF_US_CYC = HALF_US_NS * CLK_MHZ / 1000;
    localparam int ADC_STEP_MA = 125;
    localparam int OCD_STEP_MA = 375;

    // Sync source codes above this are unused
    localparam logic [2:0] SYNC_SRC_MAX = 3'h4;
    localparam int ELECTRICAL_POSITION_W = 9;

    typedef struct packed {
        logic write;
        logic [4:0] addr;
        logic [7:0] wdata;
    } reg_cmd_s;

    typedef struct packed {
        logic ocd;
        logic th_sd;
        logic th_wrn;
        logic uvlo;
        logic sw_evn;
        logic wrong_cmd;
    } alarm_cond_s;

endpackage

// [sim/host_model.sv]
// Host side of the register port: one access per pulse, at falling edges.
// Assumes a read is answered at its take edge, in time for the next falling edge.
`timescale 1ns/100ps
module host_model (
    input wire logic ref_clk,
    input wire logic rd_valid_q,
    input wire logic [7:0] rd_data_q,
    output logic cmd_valid,
    output stepper_regs_pkg::reg_cmd_s cmd,
    output logic status_fetch
);
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
        status_fetch = 1'b0;
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        cmd <= '{1'b1, a, v};
        cmd_valid <= 1'b1;
        @(negedge ref_clk);
        cmd_valid <= 1'b0;
        cmd <= '{1'b0, ~a, ~v}; // Released bus never shows the old value
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        cmd <= '{1'b0, a, 8'h00};
        cmd_valid <= 1'b1;
        @(negedge ref_clk);
        v = rd_valid_q ? rd_data_q : 8'hXX;
        cmd_valid <= 1'b0;
        @(negedge ref_clk);
    endtask
    // Absolute position lives outside this block; a real host resets it here
    task automatic step_cfg(input logic en, input logic [2:0] src, input logic [2:0] res);
        wr(stepper_regs_pkg::ADDR_STEP_CFG, {en, src, 1'b1, res});
    endtask
    task automatic fetch();
        status_fetch <= 1'b1;
        @(negedge ref_clk);
        status_fetch <= 1'b0;
        @(negedge ref_clk);
    endtask
endmodule

// [sim/stepper_regs_monitor.sv]
// Checker for the stepper register bank, on top-level ports only.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/100ps
module stepper_regs_monitor #(
    parameter int POS_W = 9
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic cmd_valid,
    input stepper_regs_pkg::reg_cmd_s cmd,
    input wire logic motor_running,
    input wire logic status_fetch,
    input wire logic step_pulse,
    input wire logic step_dir,
    input stepper_regs_pkg::alarm_cond_s alarm_cond,
    input wire logic cmd_not_performed_q,
    input wire logic [POS_W-1:0] electrical_position_q,
    input wire logic [3:0] max_fast_decay_time_q,
    input wire logic [3:0] fall_step_time_q,
    input wire logic [6:0] min_on_time_q,
    input wire logic [2:0] step_res_q,
    input wire logic [10:0] fast_decay_cycles_q,
    input wire logic [11:0] min_on_cycles_q,
    input wire logic alarm_pin_oe_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire wr_en = clk_en && cmd_valid && cmd.write;
    function automatic int inc(input logic [2:0] r);
        return r[2] ? 8 : 128 >> r;
    endfunction
    adc_ro_a: assert property (
        wr_en && cmd.addr == stepper_regs_pkg::ADDR_ADC |=> cmd_not_performed_q)
        else $error("adc write not refused");
    run_lock_a: assert property (
        wr_en && motor_running && cmd.addr == stepper_regs_pkg::ADDR_MIN_ON
        |=> $stable(min_on_time_q) && cmd_not_performed_q) else $error("locked write taken");
    flag_latch_a: assert property (
        cmd_not_performed_q && !status_fetch |=> cmd_not_performed_q) else $error("flag lost");
    fd_split_a: assert property (
        wr_en && !motor_running && cmd.addr == stepper_regs_pkg::ADDR_FAST_DECAY
        |=> {max_fast_decay_time_q, fall_step_time_q} == $past(cmd.wdata))
        else $error("fast decay fields wrong");
    fd_time_a: assert property (
        clk_en |=> int'(fast_decay_cycles_q) == (int'($past(max_fast_decay_time_q)) + 1) * 100)
        else $error("fast decay time wrong");
    on_time_a: assert property (
        clk_en |=> int'(min_on_cycles_q) == (int'($past(min_on_time_q)) + 1) * 25)
        else $error("min on time wrong");
    res_reset_a: assert property (
        wr_en && !motor_running && cmd.addr == stepper_regs_pkg::ADDR_STEP_CFG
        && cmd.wdata[2:0] != step_res_q |=> electrical_position_q == '0)
        else $error("position not reset");
    step_adv_a: assert property (
        clk_en && step_pulse && step_dir && !cmd_valid |=> electrical_position_q
        == POS_W'($past(electrical_position_q) + inc($past(step_res_q))))
        else $error("step increment wrong");
    alarm_idle_a: assert property (
        clk_en && alarm_cond == '0 && !cmd_not_performed_q |=> !alarm_pin_oe_q)
        else $error("alarm pin without cause");
endmodule

// [sim/stepper_current_step_alarm_regs_tb_top.sv]
// Self-checking bench for the stepper register bank with a host model.
// Assumes the design package is compiled first; the checker is bound below.
`timescale 1ns/100ps
module stepper_current_step_alarm_regs_tb_top;
    logic ref_clk, rst_b = 1'b0, clk_en = 1'b1, motor_running = 1'b0, cmd_busy = 1'b0;
    logic adc_valid = 1'b0, step_pulse = 1'b0, step_dir = 1'b1;
    logic [4:0] adc_code = 5'h00;
    stepper_regs_pkg::alarm_cond_s alarm_cond = '0;
    stepper_regs_pkg::reg_cmd_s cmd;
    logic cmd_valid, status_fetch, rd_valid_q, cmd_not_performed_q, busy_sync_q;
    logic alarm_pin_out_q, alarm_pin_oe_q;
    logic [7:0] rd_data_q, d;
    logic [8:0] electrical_position_q;
    logic [10:0] fast_decay_cycles_q, fall_step_cycles_q;
    logic [3:0] max_fast_decay_time_q, fall_step_time_q, overcurrent_threshold_q;
    logic [6:0] min_on_time_q, min_off_time_q;
    logic [2:0] step_res_q;
    logic [11:0] min_on_cycles_q, min_off_cycles_q;
    logic [12:0] ocd_trip_ma_q, adc_current_ma_q;
    int miscompares = 0, comparisons = 0;

    stepper_current_step_alarm_regs DUT (.ref_clk, .rst_b, .clk_en, .cmd_valid, .cmd,
        .motor_running, .cmd_busy, .status_fetch, .adc_valid, .adc_code, .step_pulse, .step_dir,
        .alarm_cond, .rd_valid_q, .rd_data_q, .cmd_not_performed_q, .electrical_position_q,
        .max_fast_decay_time_q, .fall_step_time_q, .min_on_time_q, .min_off_time_q,
        .overcurrent_threshold_q, .step_res_q, .fast_decay_cycles_q, .fall_step_cycles_q,
        .min_on_cycles_q, .min_off_cycles_q, .ocd_trip_ma_q, .adc_current_ma_q, .busy_sync_q,
        .alarm_pin_out_q, .alarm_pin_oe_q);
    host_model host (.ref_clk, .rd_valid_q, .rd_data_q, .cmd_valid, .cmd, .status_fetch);

    task automatic chk(input logic [15:0] got, input int exp);
        comparisons++;
        if (got !== 16'(exp)) begin
            miscompares++;
            $display("Error at %0t: saw %h, wanted %h", $time, got, 16'(exp));
        end
    endtask
    task automatic step(input logic up);
        step_dir <= up;
        step_pulse <= 1'b1;
        @(negedge ref_clk);
        step_pulse <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic t_reset();
        logic [4:0] ad[7] = '{5'h0E, 5'h0F, 5'h10, 5'h13, 5'h16, 5'h17, 5'h1F};
        logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'hFF, 8'h00};
        for (int i = 0; i < 7; i++) begin
            host.rd(ad[i], d);
            chk(d, rv[i]);
        end
        chk(ocd_trip_ma_q, 375);
        chk(busy_sync_q, 1);
    endtask
    task automatic t_timing();
        host.wr(stepper_regs_pkg::ADDR_FAST_DECAY, 8'hF0);
        chk(max_fast_decay_time_q, 15);
        chk(fall_step_time_q, 0);
        chk(fast_decay_cycles_q, 16 * 100);
        chk(fall_step_cycles_q, 100);
        host.wr(stepper_regs_pkg::ADDR_MIN_ON, 8'h7F);
        chk(min_on_cycles_q, 128 * 25);
        host.wr(stepper_regs_pkg::ADDR_MIN_OFF, 8'h7E);
        chk(min_off_time_q, 8'h7E);
        chk(min_off_cycles_q, 127 * 25);
        host.wr(stepper_regs_pkg::ADDR_OVERCURRENT_THRESHOLD, 8'h0F);
        chk(ocd_trip_ma_q, 16 * 375);
    endtask
    task automatic t_lock();
        logic [4:0] la[4] = '{5'h0E, 5'h0F, 5'h10, 5'h16};
        logic [7:0] lv[4] = '{8'hF0, 8'h7F, 8'h7E, 8'h08};
        motor_running <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            host.fetch();
            host.wr(la[i], 8'h55);
            chk(cmd_not_performed_q, 1);
            host.rd(la[i], d);
            chk(d, lv[i]);
        end
        chk(alarm_pin_oe_q, 1);
        chk(alarm_pin_out_q, 0);
        host.fetch();
        host.wr(stepper_regs_pkg::ADDR_OVERCURRENT_THRESHOLD, 8'h03);
        chk(overcurrent_threshold_q, 3);
        chk(cmd_not_performed_q, 0);
        motor_running <= 1'b0;
        adc_code <= 5'h1F;
        adc_valid <= 1'b1;
        @(negedge ref_clk);
        adc_valid <= 1'b0;
        host.wr(stepper_regs_pkg::ADDR_ADC, 8'h00);
        host.rd(stepper_regs_pkg::ADDR_ADC, d);
        chk(d, 8'h1F);
        chk(adc_current_ma_q, 32 * 125);
        chk(cmd_not_performed_q, 1);
        host.fetch();
        chk(cmd_not_performed_q, 0);
    endtask
    task automatic t_step();
        logic [2:0] rs[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
        for (int i = 0; i < 6; i++) begin
            host.step_cfg(1'b0, 3'h0, rs[i]);
            chk(electrical_position_q, 0);
            chk(step_res_q, rs[i]);
            step(1'b1);
            chk(electrical_position_q, rs[i][2] ? 8 : 128 >> rs[i]);
        end
        step(1'b0);
        step(1'b0);
        chk(electrical_position_q, 512 - 8);
    endtask
    task automatic t_sync();
        host.step_cfg(1'b0, 3'h0, 3'h4);
        cmd_busy <= 1'b1;
        @(negedge ref_clk);
        chk(busy_sync_q, 0);
        cmd_busy <= 1'b0;
        // Position 248 sets bits 7..3 only, so a shifted tap reads 0
        repeat (31) step(1'b1);
        chk(busy_sync_q, 1);
        for (int s = 0; s < 8; s++) begin
            host.step_cfg(1'b1, 3'(s), 3'h4);
            chk(busy_sync_q, s <= 4);
        end
    endtask
    task automatic t_alarm();
        int bi[6] = '{0, 1, 2, 3, 6, 7};
        for (int i = 0; i < 6; i++) begin
            alarm_cond <= 6'h20 >> i;
            host.wr(stepper_regs_pkg::ADDR_ALARM_MASK, 8'h01 << bi[i]);
            chk(alarm_pin_oe_q, 1);
            host.wr(stepper_regs_pkg::ADDR_ALARM_MASK, ~(8'h01 << bi[i]));
            chk(alarm_pin_oe_q, 0);
        end
        alarm_cond <= '0;
    endtask
    // Frozen clock enable: neither a write nor a step may land
    task automatic t_freeze();
        clk_en <= 1'b0;
        host.wr(stepper_regs_pkg::ADDR_OVERCURRENT_THRESHOLD, 8'h09);
        step(1'b1);
        chk(overcurrent_threshold_q, 3);
        chk(electrical_position_q, 248);
        clk_en <= 1'b1;
        @(negedge ref_clk);
        chk(ocd_trip_ma_q, 4 * 375);
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever begin
            #10;
            ref_clk = ~ref_clk;
        end
    end
    initial begin
        repeat (12) @(negedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        t_reset();
        t_timing();
        t_lock();
        t_step();
        t_sync();
        t_alarm();
        t_freeze();
        wrap_up();
    end
    // Whole run is a few hundred cycles; this is twelve times that
    initial begin
        #50us;
        miscompares++;
        wrap_up();
    end
endmodule

bind stepper_current_step_alarm_regs stepper_regs_monitor #(.POS_W(POS_W)) mon (.ref_clk, .rst_b,
    .clk_en, .cmd_valid, .cmd, .motor_running, .status_fetch, .step_pulse, .step_dir, .alarm_cond,
    .cmd_not_performed_q, .electrical_position_q, .max_fast_decay_time_q, .fall_step_time_q,
    .min_on_time_q, .step_res_q, .fast_decay_cycles_q, .min_on_cycles_q, .alarm_pin_oe_q);
